/* File: board_info_regs.sv */
// board information registers and board command register
`timescale 1ns/10ps
module board_info_regs #(
  parameter logic [15:0] PROD_YEAR    = 16'h07E2, // plain default
  parameter logic [7:0]  PROD_MONTH   = 8'h05,    // plain default
  parameter logic [31:0] SERIAL_NO    = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] MAX_RATE_HZ  = 32'h0007_A120, // plain default
  parameter logic [31:0] MEM_BYTES    = 32'h0100_0000, // plain default
  parameter logic [31:0] OPTIONS      = 32'h0000_0001, // plain default
  parameter logic [31:0] IRQ_LINE     = 32'h0000_000B  // plain default
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [31:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  output logic             run_active,
  output logic             low_power,
  output logic             settings_reset,
  output logic             mem_valid,
  output logic      [31:0] sample_capacity,
  input  wire logic        acq_done
);

  // options word after the hub-implies-sync fixup
  logic [31:0] options_word;
  // state registers
  board_info_pkg::mode_t mode_reg, mode_next;
  logic [31:0] cmd_reg, cmd_next;       // last command written
  logic        valid_reg, valid_next;   // memory holds good data
  logic        rst_pulse_reg, rst_pulse_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;

  // address match helper, used by both decoders
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // options word
  // hub sets sync
  // masks only from straps; same mechanism
  always_comb begin
    options_word = OPTIONS;
    if ((OPTIONS & board_info_pkg::OPT_HUB_MODULE) != 32'h0000_0000) begin
      options_word = options_word | board_info_pkg::OPT_SYNCHRONIZATION;
    end
  end

  // read decode: pure mux, nothing changes on a read
  // reads side-effect free
  always_comb begin
    rdata_next = rdata_reg;
    ack_next   = 1'b0;
    if (reg_rd) begin
      ack_next = 1'b1;
      if (hit(reg_addr, board_info_pkg::BOARD_COMMAND_ADDR)) begin
        rdata_next = cmd_reg;
      end else if (hit(reg_addr, board_info_pkg::PRODUCTION_DATE_ADDR)) begin
        rdata_next = {PROD_YEAR, 8'h00, PROD_MONTH};
      end else if (hit(reg_addr, board_info_pkg::BOARD_SERIAL_ADDR)) begin
        rdata_next = SERIAL_NO;
      end else if (hit(reg_addr, board_info_pkg::MAX_SAMPLE_RATE_ADDR)) begin
        rdata_next = MAX_RATE_HZ;
      end else if (hit(reg_addr, board_info_pkg::MEMORY_SIZE_BYTES_ADDR))
      begin
        rdata_next = MEM_BYTES;
      end else if (hit(reg_addr, board_info_pkg::INSTALLED_OPTIONS_ADDR))
      begin
        rdata_next = options_word;
      end else if (hit(reg_addr, board_info_pkg::IRQ_LINE_USED_ADDR)) begin
        rdata_next = IRQ_LINE;
      end else begin
        // unmapped reads return zero
        rdata_next = 32'h0000_0000;
      end
    end else if (reg_wr) begin
      // writes are acknowledged too; a write to a read-only word is dropped
      ack_next = 1'b1;
    end
  end

  // command decode and board mode
  always_comb begin
    mode_next      = mode_reg;
    cmd_next       = cmd_reg;
    valid_next     = valid_reg;
    rst_pulse_next = 1'b0;
    // acquisition finishing fills memory with good data
    if (acq_done && mode_reg == board_info_pkg::MODE_RUN) begin
      valid_next = 1'b1;
    end
    // read wins over write if both asserted: host issues one at a time
    if (reg_wr && !reg_rd &&
        hit(reg_addr, board_info_pkg::BOARD_COMMAND_ADDR)) begin
      cmd_next = reg_wdata;
      case (reg_wdata)
        board_info_pkg::BOARD_RESET_CMD: begin
          mode_next      = board_info_pkg::MODE_IDLE;
          rst_pulse_next = 1'b1;
          valid_next     = 1'b0;
          cmd_next       = board_info_pkg::COMMAND_RESET;
        end
        board_info_pkg::RUN_CMD: begin
          mode_next = board_info_pkg::MODE_RUN;
        end
        board_info_pkg::LOW_POWER_CMD: begin
          mode_next  = board_info_pkg::MODE_LOW_POWER;
          valid_next = 1'b0;
        end
        default: begin
          // other codes belong to blocks outside this bank
        end
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg      <= board_info_pkg::MODE_IDLE;
      cmd_reg       <= board_info_pkg::COMMAND_RESET;
      valid_reg     <= 1'b0;
      rst_pulse_reg <= 1'b0;
      rdata_reg     <= 32'h0000_0000;
      ack_reg       <= 1'b0;
    end else if (ce) begin
      mode_reg      <= mode_next;
      cmd_reg       <= cmd_next;
      valid_reg     <= valid_next;
      rst_pulse_reg <= rst_pulse_next;
      rdata_reg     <= rdata_next;
      ack_reg       <= ack_next;
    end
  end

  // outputs
  assign reg_rdata      = rdata_reg;
  assign reg_ack        = ack_reg;
  assign run_active     = (mode_reg == board_info_pkg::MODE_RUN);
  assign low_power      = (mode_reg == board_info_pkg::MODE_LOW_POWER);
  assign settings_reset = rst_pulse_reg;
  assign mem_valid      = valid_reg;
  assign sample_capacity = MEM_BYTES >> board_info_pkg::SAMPLE_BYTES_SHIFT;

  // low power command drops valid data and mode
  low_power_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_wr && !reg_rd && reg_addr == 32'h0000_0000 &&
    reg_wdata == 32'h0000_001E |=> low_power && !mem_valid)
    else $error("low power command not taken");
  // start leaves low power
  start_wake_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && low_power && reg_wr && !reg_rd && reg_addr == 32'h0000_0000 &&
    reg_wdata == 32'h0000_000A |=> run_active && !low_power)
    else $error("start did not leave low power");
  // reset command clears mode and memory
  reset_cmd_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_wr && !reg_rd && reg_addr == 32'h0000_0000 &&
    reg_wdata == 32'h0000_0000 |=> settings_reset && !mem_valid &&
    !low_power && !run_active)
    else $error("reset command not taken");
  // start command enters run
  run_cmd_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_wr && !reg_rd && reg_addr == 32'h0000_0000 &&
    reg_wdata == 32'h0000_000A |=> run_active)
    else $error("start command not taken");
  // date word layout
  date_word_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && reg_addr == 32'h0000_07E4 |=>
    reg_ack && reg_rdata[15:8] == 8'h00 &&
    reg_rdata[31:16] == PROD_YEAR && reg_rdata[7:0] == PROD_MONTH)
    else $error("date word wrong");
  // hub implies sync on readout
  hub_sync_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && reg_addr == 32'h0000_0848 |=>
    !reg_rdata[11] || reg_rdata[9])
    else $error("hub without sync bit");
  // reads leave mode and validity alone
  read_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && !acq_done |=> $stable(mode_reg) && $stable(valid_reg))
    else $error("read changed state");
  // memory size word
  mem_size_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && reg_addr == 32'h0000_083E |=> reg_rdata == MEM_BYTES)
    else $error("memory size wrong");
  // capacity halves bytes
  capacity_a: assert property (@(posedge clk) disable iff (!nrst)
    sample_capacity + sample_capacity == {MEM_BYTES[31:1], 1'b0})
    else $error("capacity wrong");
  // serial read
  serial_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd && reg_addr == 32'h0000_07EE |=> reg_rdata == SERIAL_NO)
    else $error("serial wrong");

  // sample rate word comes straight from the strap
  rate_word_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::MAX_SAMPLE_RATE_ADDR |=>
    reg_rdata == MAX_RATE_HZ)
    else $error("sample rate wrong");
  // every installed option bit shows on readout
  options_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::INSTALLED_OPTIONS_ADDR |=>
    (reg_rdata & OPTIONS) == OPTIONS)
    else $error("option bit lost");
  // no option bit other than sync appears that was not installed
  options_extra_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::INSTALLED_OPTIONS_ADDR |=>
    (reg_rdata & ~(OPTIONS | board_info_pkg::OPT_SYNCHRONIZATION)) ==
    32'h0000_0000)
    else $error("option bit invented");
  // sync bit set for any kind of synchronization
  sync_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::INSTALLED_OPTIONS_ADDR |=>
    reg_rdata[9] == (OPTIONS[9] || OPTIONS[11]))
    else $error("sync bit wrong");
  // time tag bit follows its strap
  time_tag_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::INSTALLED_OPTIONS_ADDR |=>
    reg_rdata[10] == OPTIONS[10])
    else $error("time tag bit wrong");
  // extra io and amplifier bits follow their straps
  extra_io_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::INSTALLED_OPTIONS_ADDR |=>
    reg_rdata[13] == OPTIONS[13] && reg_rdata[14] == OPTIONS[14])
    else $error("extra io bit wrong");
  // interrupt line word
  irq_line_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::IRQ_LINE_USED_ADDR |=>
    reg_rdata == IRQ_LINE)
    else $error("interrupt line wrong");
  // command register reads back what it held
  cmd_readback_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_rd &&
    reg_addr == board_info_pkg::BOARD_COMMAND_ADDR |=>
    reg_rdata == $past(cmd_reg))
    else $error("command readback wrong");
  // every enabled request is answered one edge later
  ack_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && (reg_rd || reg_wr) |=> reg_ack)
    else $error("request not answered");
  // no answer without a request
  ack_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && !reg_rd && !reg_wr |=> !reg_ack)
    else $error("answer without request");
  // writes to other numbers touch no board state
  write_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && reg_wr && !reg_rd && !acq_done &&
    reg_addr != board_info_pkg::BOARD_COMMAND_ADDR |=>
    $stable(mode_reg) && $stable(cmd_reg) && $stable(valid_reg))
    else $error("ignored write changed state");
  // memory is never valid while powered down
  power_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    low_power |-> !mem_valid)
    else $error("valid memory in low power");
  // settings reset is a single pulse
  reset_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && settings_reset && !reg_wr |=> !settings_reset)
    else $error("settings reset stuck");
  // clock enable low freezes mode, command and answer
  freeze_a: assert property (@(posedge clk) disable iff (!nrst)
    !ce |=> $stable(mode_reg) && $stable(cmd_reg) && $stable(reg_ack))
    else $error("state moved while frozen");

endmodule // board_info_regs

/* File: board_info_pkg.sv */
// package: register numbers, option masks, command codes and defaults
package board_info_pkg;
  // register numbers as the software addresses them
  localparam logic [31:0] BOARD_COMMAND_ADDR     = 32'h0000_0000;
  localparam logic [31:0] PRODUCTION_DATE_ADDR   = 32'h0000_07E4;
  localparam logic [31:0] BOARD_SERIAL_ADDR      = 32'h0000_07EE;
  localparam logic [31:0] MAX_SAMPLE_RATE_ADDR   = 32'h0000_0834;
  localparam logic [31:0] MEMORY_SIZE_BYTES_ADDR = 32'h0000_083E;
  localparam logic [31:0] INSTALLED_OPTIONS_ADDR = 32'h0000_0848;
  localparam logic [31:0] IRQ_LINE_USED_ADDR     = 32'h0000_08FC;
  // command codes
  localparam logic [31:0] BOARD_RESET_CMD        = 32'h0000_0000;
  localparam logic [31:0] RUN_CMD                = 32'h0000_000A;
  localparam logic [31:0] LOW_POWER_CMD          = 32'h0000_001E;
  // reset value of the command register
  localparam logic [31:0] COMMAND_RESET          = 32'h0000_0000;
  // production date field positions
  localparam int          DATE_YEAR_LSB          = 16;
  localparam int          DATE_MONTH_MSB         = 7;
  // installed option masks
  localparam logic [31:0] OPT_MULTI_RECORD       = 32'h0000_0001;
  localparam logic [31:0] OPT_DIGITAL_IO         = 32'h0000_0002;
  localparam logic [31:0] OPT_GATED_SAMPLING     = 32'h0000_0020;
  localparam logic [31:0] OPT_SYNCHRONIZATION    = 32'h0000_0200;
  localparam logic [31:0] OPT_TIME_TAG           = 32'h0000_0400;
  localparam logic [31:0] OPT_HUB_MODULE         = 32'h0000_0800;
  localparam logic [31:0] OPT_EXTRA_IO           = 32'h0000_2000;
  localparam logic [31:0] OPT_AMP_CALIBRATION    = 32'h0000_4000;
  // log2 of the bytes per stored sample on a 16-bit board
  localparam int          SAMPLE_BYTES_SHIFT     = 1;
  // board mode
  typedef enum logic [1:0] {MODE_IDLE, MODE_RUN, MODE_LOW_POWER} mode_t;
endpackage

/* File: host_driver_model.sv */
// host driver model: one register transfer at a time over the board's port
`timescale 1ns/10ps
module host_driver_model (
  input  wire logic        clk,
  output logic             ce,
  output logic      [31:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack
);
  logic ack_seen; // answer flag of the last transfer
  // idle bus until the first transfer
  initial begin
    ce = 1'b1;
    reg_addr = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // clock enable change, made just after an edge between transfers
  task automatic hold_ce(input logic v);
    @(posedge clk);
    ce <= v;
  endtask
  // command codes go to register zero
  // released lines carry inverted values so stale data never passes
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= ~wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    ack_seen = reg_ack;
    q = reg_rdata;
  endtask
endmodule // host_driver_model

/* File: board_info_regs_test.sv */
// testbench: information reads and board commands
`timescale 1ns/10ps
module board_info_regs_test;
  localparam logic [31:0] OPTS = board_info_pkg::OPT_MULTI_RECORD |
    board_info_pkg::OPT_DIGITAL_IO | board_info_pkg::OPT_GATED_SAMPLING |
    board_info_pkg::OPT_TIME_TAG | board_info_pkg::OPT_HUB_MODULE |
    board_info_pkg::OPT_EXTRA_IO | board_info_pkg::OPT_AMP_CALIBRATION;
  localparam logic [31:0] MEM = 32'h0200_0000; // installed bytes
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        acq_done = 1'b0;
  logic        ce, reg_wr, reg_rd, reg_ack;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, sample_capacity, q;
  logic        run_active, low_power, settings_reset, mem_valid;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  // serial 5A5A is arbitrary; hub set without sync to test forcing
  board_info_regs #(.PROD_YEAR(16'h07E3), .PROD_MONTH(8'h0C),
    .SERIAL_NO(32'h0000_5A5A), .MAX_RATE_HZ(32'h0003_D090), .MEM_BYTES(MEM),
    .OPTIONS(OPTS), .IRQ_LINE(32'h0000_0009)) board_info_regs_inst (
    .clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .run_active(run_active), .low_power(low_power),
    .settings_reset(settings_reset), .mem_valid(mem_valid),
    .sample_capacity(sample_capacity), .acq_done(acq_done));
  host_driver_model host_driver_model_inst (.clk(clk), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    host_driver_model_inst.xfer(1'b0, a, 32'h0000_0000, q);
    chk("read ack", 32'h1, 32'(host_driver_model_inst.ack_seen));
    chk("read data", e, q);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_driver_model_inst.xfer(1'b1, a, d, q);
    chk("write ack", 32'h1, 32'(host_driver_model_inst.ack_seen));
  endtask
  // acquisition end pulse while running marks memory valid
  task automatic acq();
    @(posedge clk);
    acq_done <= 1'b1;
    @(posedge clk);
    acq_done <= 1'b0;
    #1;
    chk("mem_valid", 32'h1, 32'(mem_valid));
  endtask
  task automatic t_info();
    rd(board_info_pkg::PRODUCTION_DATE_ADDR, 32'h07E3_000C);
    rd(board_info_pkg::BOARD_SERIAL_ADDR, 32'h0000_5A5A);
    rd(board_info_pkg::MAX_SAMPLE_RATE_ADDR, 32'h0003_D090);
    rd(board_info_pkg::MEMORY_SIZE_BYTES_ADDR, MEM);
    chk("capacity", MEM >> 1, sample_capacity);
    rd(board_info_pkg::INSTALLED_OPTIONS_ADDR, OPTS | 32'h0000_0200);
    rd(board_info_pkg::INSTALLED_OPTIONS_ADDR, 32'h0000_6E23);
    rd(board_info_pkg::IRQ_LINE_USED_ADDR, 32'h0000_0009);
    rd(32'h0000_0004, 32'h0000_0000); // unmapped reads as zero
    chk("run_active", 32'h0, 32'(run_active));
  endtask
  // clock enable low: requests are neither answered nor applied
  task automatic t_freeze();
    host_driver_model_inst.hold_ce(1'b0);
    host_driver_model_inst.xfer(1'b0, board_info_pkg::BOARD_SERIAL_ADDR,
      32'h0000_0000, q);
    chk("frozen ack", 32'h0, 32'(host_driver_model_inst.ack_seen));
    chk("frozen data", 32'h0, q);
    host_driver_model_inst.xfer(1'b1, board_info_pkg::BOARD_COMMAND_ADDR,
      board_info_pkg::RUN_CMD, q);
    chk("frozen run_active", 32'h0, 32'(run_active));
    host_driver_model_inst.hold_ce(1'b1);
  endtask
  task automatic t_modes();
    rd(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::COMMAND_RESET);
    wr(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::RUN_CMD);
    chk("run_active", 32'h1, 32'(run_active));
    acq();
    wr(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::LOW_POWER_CMD);
    chk("low_power", 32'h1, 32'(low_power));
    chk("mem_valid", 32'h0, 32'(mem_valid));
    rd(board_info_pkg::BOARD_COMMAND_ADDR, 32'h0000_001E);
    wr(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::RUN_CMD);
    chk("low_power", 32'h0, 32'(low_power));
    acq();
    wr(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::BOARD_RESET_CMD);
    chk("settings_reset", 32'h1, 32'(settings_reset));
    chk("mem_valid", 32'h0, 32'(mem_valid));
    chk("run_active", 32'h0, 32'(run_active));
    @(posedge clk);
    #1;
    chk("settings_reset", 32'h0, 32'(settings_reset));
    wr(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::LOW_POWER_CMD);
    wr(board_info_pkg::BOARD_COMMAND_ADDR, board_info_pkg::BOARD_RESET_CMD);
    chk("low_power", 32'h0, 32'(low_power));
    wr(board_info_pkg::MEMORY_SIZE_BYTES_ADDR, 32'h0000_0000);
    rd(board_info_pkg::MEMORY_SIZE_BYTES_ADDR, MEM);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_info();
    t_freeze();
    t_modes();
    results();
  end
endmodule // board_info_regs_test
